// ---- hw/psl_cfg.svh ----
// Constants for the strap latch: pin indices, offsets, field bits, resets.
// Assumes nothing; included by bare name wherever a number is needed.
`ifndef PSL_CFG_SVH
`define PSL_CFG_SVH

// ====================================================
// Strap pin indices on the shared pin vector
`define PSL_STRAP_W 13
`define PSL_IDX_ADDR 0
`define PSL_ADDR_W 5
`define PSL_IDX_LPBK 5
`define PSL_IDX_ISO 6
`define PSL_IDX_RMII 7
`define PSL_IDX_BTB 8
`define PSL_IDX_SPD 9
`define PSL_IDX_DUP 10
`define PSL_IDX_ANEG 11
`define PSL_IDX_FIBER 12
// Pull defaults: address 00001, speed, duplex, autoneg up
`define PSL_STRAP_DEF 13'h0e01

// ====================================================
// Register byte offsets
`define PSL_OFS_CTRL 4'h0
`define PSL_OFS_ADV 4'h4
`define PSL_OFS_STAT 4'h8

// ====================================================
// Control image fields and reset value
`define PSL_CTRL_SPD 13
`define PSL_CTRL_ANEG 12
`define PSL_CTRL_ISO 10
`define PSL_CTRL_DUP 8
`define PSL_CTRL_DEF 16'h3100
`define PSL_CTRL_WMASK 16'h3500

// ====================================================
// Advertisement image fields and reset value
`define PSL_ADV_100FD 8
`define PSL_ADV_100HD 7
`define PSL_ADV_10FD 6
`define PSL_ADV_10HD 5
`define PSL_ADV_SEL 5'h01
`define PSL_ADV_DEF 16'h01e1
`define PSL_ADV_WMASK 16'h01e0

// ====================================================
// Least chip reset pulse kept by the board
`define PSL_RST_MIN_NS 50000
`define PSL_CLK_NS 100
`define PSL_RST_MIN_CYC ((`PSL_RST_MIN_NS + `PSL_CLK_NS - 1) / `PSL_CLK_NS)

`endif

// ---- hw/psl_pkg.sv ----
// Types shared by the strap latch modules.
// Assumes psl_cfg.svh holds every number.
package psl_pkg;

    // ====================================================
    // Pin ownership: held as inputs, or driven as outputs
    typedef enum logic {PSL_HOLD, PSL_RUN} psl_state_t;

endpackage : psl_pkg

// ---- hw/psl_capture.sv ----
// Strap capture bank: one flip-flop per strap pin.
// Assumes capture is a one-cycle pulse made by the owner of the pins.
`timescale 1ns/10ps

module psl_capture #(
    parameter int W = 13,
    parameter logic [W-1:0] DEF = '0
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic sys_rst,
    // Capture strobe and pins
    input wire logic capture,
    input wire logic [W-1:0] pin_in,
    // Latched straps
    output logic [W-1:0] strap
);

    // ====================================================
    // Per-bit latch, reset to the pull default of that pin
    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_bit
            always_ff @(posedge core_clk or posedge sys_rst) begin
                if (sys_rst) begin
                    strap[i] <= DEF[i];
                end else if (capture) begin
                    strap[i] <= pin_in[i];
                end
            end
        end
    endgenerate

endmodule : psl_capture

// ---- hw/psl_pin_drive.sv ----
// Output stage of the shared strap pins.
// Assumes drive_en is low whenever the pins must float for capture.
`timescale 1ns/10ps

module psl_pin_drive #(
    parameter int W = 13
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic sys_rst,
    // Drive request and values
    input wire logic drive_en,
    input wire logic [W-1:0] value,
    // Pin output and enable
    output logic [W-1:0] pin_out,
    output logic [W-1:0] pin_oe
);

    // ====================================================
    // Registered drive; pins float under reset
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            pin_out <= '0;
            pin_oe <= '0;
        end else begin
            pin_out <= value;
            pin_oe <= {W{drive_en}};
        end
    end

endmodule : psl_pin_drive

// ---- hw/psl_top.sv ----
// Strap latch of a 10/100 transceiver: pin capture, config images, pin drive.
// Assumes chip_rst_n and the strap pins are synchronous to core_clk.
// What this block and its board must do
// R1 - The board holds chip reset low at least fifty microseconds.
// R2 - Sample every strap during reset; keep the values as defaults afterwards.
// R3 - Strap pins float as inputs in reset and are driven afterwards.
// R4 - Capture a five-bit management address; unstrapped it reads 00001.
// R5 - Loopback strap high enables loopback; low leaves it off.
// R6 - Isolate strap high enables isolate; low leaves it off.
// R7 - Reduced-interface strap high selects RMII; low keeps full MII.
// R8 - Back-to-back strap high enables reduced back-to-back mode.
// R9 - Speed strap loads control bit 13: low 10, high 100 Mbps.
// R10 - Speed strap value also loads the advertised 100 Mbps abilities.
// R11 - In fiber mode a low speed strap disables far-end fault.
// R12 - Duplex strap loads control bit 8: low half, high full.
// R13 - Duplex strap value also loads the advertised full-duplex abilities.
// R14 - Autoneg strap loads control bit 12: low off, high on.
// R15 - Power-down input low enters power-down; high runs normally.
// R16 - The board supplies a crystal or 25 MHz reference clock.
// R17 - Board may add pull-downs where other logic drives pins at power-up.
// R18 - After reset the duplex pin shows duplex: low full, high half.
// R19 - All straps are registered together on the reset release edge.
`timescale 1ns/10ps
`include "psl_cfg.svh"

module psl_top (
    // Clock and reset
    input wire logic core_clk,
    input wire logic sys_rst,
    // Chip reset pin and power-down pin
    input wire logic chip_rst_n,
    input wire logic power_down_n,
    // Shared strap pins
    input wire logic [`PSL_STRAP_W-1:0] strap_pin_in,
    output logic [`PSL_STRAP_W-1:0] strap_pin_out,
    output logic [`PSL_STRAP_W-1:0] strap_pin_oe,
    // Normal pin functions from the data path
    input wire logic [`PSL_STRAP_W-1:0] pin_func_out,
    // Avalon-MM slave
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [3:0] avs_byteenable,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // Latched configuration and status flags
    output logic [`PSL_ADDR_W-1:0] mgmt_station_addr,
    output logic coding_loopback,
    output logic rmii_mode,
    output logic reduced_btb_mode,
    output logic fiber_mode,
    output logic far_fault_disable,
    output logic power_down,
    output logic config_done
);

    // ====================================================
    // State and images
    psl_pkg::psl_state_t state;
    psl_pkg::psl_state_t next_state;
    logic [`PSL_STRAP_W-1:0] strap;
    logic [15:0] ctrl;
    logic [15:0] adv;
    logic [15:0] next_ctrl;
    logic [15:0] next_adv;

    // ====================================================
    // Pin ownership sequencing
    wire in_hold = (state == psl_pkg::PSL_HOLD);
    wire capture = in_hold & chip_rst_n; // R19
    wire drive_en = (state == psl_pkg::PSL_RUN);
    assign next_state = !chip_rst_n ? psl_pkg::PSL_HOLD :
                        capture ? psl_pkg::PSL_RUN : state;

    // State loads next_state on every edge
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            state <= psl_pkg::PSL_HOLD;
        end else begin
            state <= next_state;
        end
    end

    // ====================================================
    // Strap bank, loaded at the release edge only
    psl_capture #(
        .W(`PSL_STRAP_W),
        .DEF(`PSL_STRAP_DEF)
    ) u_capture (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .capture(capture), // R2
        .pin_in(strap_pin_in),
        .strap(strap)
    );

    // Latched modes straight from the bank
    assign mgmt_station_addr = strap[`PSL_IDX_ADDR +: `PSL_ADDR_W]; // R4
    assign coding_loopback = strap[`PSL_IDX_LPBK]; // R5
    assign rmii_mode = strap[`PSL_IDX_RMII]; // R7
    assign reduced_btb_mode = strap[`PSL_IDX_BTB]; // R8
    assign fiber_mode = strap[`PSL_IDX_FIBER];

    // ====================================================
    // Strap-derived images, taken from the pins at the capture edge
    wire p_spd = strap_pin_in[`PSL_IDX_SPD];
    wire p_dup = strap_pin_in[`PSL_IDX_DUP];
    wire p_aneg = strap_pin_in[`PSL_IDX_ANEG];
    wire p_iso = strap_pin_in[`PSL_IDX_ISO]; // R6
    wire p_fiber = strap_pin_in[`PSL_IDX_FIBER];
    wire [15:0] cap_ctrl = {2'h0, p_spd, p_aneg, 1'b0, p_iso, 1'b0, p_dup, 8'h00};
    wire [15:0] cap_adv = {7'h00, p_spd & p_dup, p_spd, p_dup, 1'b1, `PSL_ADV_SEL};

    // ====================================================
    // Bus decode
    wire req = avs_read | avs_write;
    wire wr_fire = avs_write & ~avs_waitrequest;
    wire sel_ctrl = (avs_address == `PSL_OFS_CTRL);
    wire sel_adv = (avs_address == `PSL_OFS_ADV);
    wire sel_stat = (avs_address == `PSL_OFS_STAT);
    wire [15:0] be_mask = {{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
    wire [15:0] wr_ctrl = be_mask & `PSL_CTRL_WMASK;
    wire [15:0] wr_adv = be_mask & `PSL_ADV_WMASK;
    wire [15:0] stat = {config_done, power_down, far_fault_disable, strap};
    wire [15:0] rd_sel = sel_ctrl ? ctrl :
                         sel_adv ? adv :
                         sel_stat ? stat : 16'h0000;

    // Capture outranks a software write in the same cycle
    assign next_ctrl = capture ? cap_ctrl : // R9 R12 R14
                       (wr_fire & sel_ctrl) ?
                       ((ctrl & ~wr_ctrl) | (avs_writedata[15:0] & wr_ctrl)) : ctrl;
    assign next_adv = capture ? cap_adv : // R10 R13
                      (wr_fire & sel_adv) ?
                      ((adv & ~wr_adv) | (avs_writedata[15:0] & wr_adv)) : adv;

    // Image registers
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            ctrl <= `PSL_CTRL_DEF;
            adv <= `PSL_ADV_DEF;
        end else begin
            ctrl <= next_ctrl;
            adv <= next_adv;
        end
    end

    // ====================================================
    // Bus answer: one wait cycle, data registered
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            avs_waitrequest <= 1'b1;
            avs_readdata <= 32'h0000_0000;
        end else begin
            avs_waitrequest <= ~(req & avs_waitrequest);
            if (avs_read & avs_waitrequest) begin
                avs_readdata <= {16'h0000, rd_sel};
            end
        end
    end

    // ====================================================
    // Status flags
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            far_fault_disable <= 1'b0;
            power_down <= 1'b0;
            config_done <= 1'b0;
        end else begin
            if (capture) begin
                far_fault_disable <= p_fiber & ~p_spd; // R11
            end
            power_down <= ~power_down_n; // R15
            config_done <= (next_state == psl_pkg::PSL_RUN);
        end
    end

    // ====================================================
    // Pin values once driven: indicators active low
    logic [`PSL_STRAP_W-1:0] pin_val;
    always_comb begin
        pin_val = pin_func_out;
        pin_val[`PSL_IDX_SPD] = ~ctrl[`PSL_CTRL_SPD];
        pin_val[`PSL_IDX_DUP] = ~ctrl[`PSL_CTRL_DUP]; // R18
    end

    psl_pin_drive #(
        .W(`PSL_STRAP_W)
    ) u_drive (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .drive_en(drive_en), // R3
        .value(pin_val),
        .pin_out(strap_pin_out),
        .pin_oe(strap_pin_oe)
    );

    // ====================================================
    // Checks on pin ownership
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);

    // Held pins float, so the board levels are what the bank sees
    a_pins_float: assert property (in_hold |=> strap_pin_oe == '0) // R3
        else $error("strap pins driven while held");

    // One edge after release every shared pin is an output
    a_pins_driven: assert property (in_hold ##1 drive_en |=> &strap_pin_oe) // R3
        else $error("strap pins not driven after release");

    // A new chip reset hands the pins back to the straps
    a_pins_return: assert property (drive_en && !chip_rst_n |=> ##1 strap_pin_oe == '0) // R3
        else $error("strap pins kept driven in chip reset");

    // The duplex pin lights for full duplex once driven
    a_dup_pin: assert property (drive_en |=> // R18
        strap_pin_out[`PSL_IDX_DUP] == !$past(ctrl[`PSL_CTRL_DUP]))
        else $error("duplex indicator wrong");

    // ====================================================
    // Checks on the strap bank

    // Every strap bit is taken at the same edge
    a_capture_all: assert property (capture |=> strap == $past(strap_pin_in)) // R19
        else $error("straps not captured together");

    // Pin changes outside the capture edge are ignored
    a_strap_kept: assert property (!capture |=> $stable(strap)) // R2
        else $error("strap value changed outside capture");

    // Management address comes from its five pins
    a_addr_latch: assert property (capture |=> // R4
        mgmt_station_addr == $past(strap_pin_in[`PSL_IDX_ADDR +: `PSL_ADDR_W]))
        else $error("address not latched");

    // Loopback, reduced interface and back-to-back modes
    a_modes_latch: assert property (capture |=> // R5 R7 R8
        coding_loopback == $past(strap_pin_in[`PSL_IDX_LPBK])
        && rmii_mode == $past(strap_pin_in[`PSL_IDX_RMII])
        && reduced_btb_mode == $past(strap_pin_in[`PSL_IDX_BTB]))
        else $error("mode straps not latched");

    // Configuration is flagged done right after the capture
    a_done_set: assert property (capture |=> config_done) // R2
        else $error("done flag not raised");

    // A chip reset withdraws the done flag at once
    a_done_clear: assert property (!chip_rst_n |=> !config_done) // R3
        else $error("done flag kept in chip reset");

    // Status reads return the latched straps
    a_stat_read: assert property (avs_read && avs_waitrequest && sel_stat |=> // R2
        avs_readdata[`PSL_STRAP_W-1:0] == $past(strap))
        else $error("status read lost the straps");

    // ====================================================
    // Checks on the control and advertisement images

    // Isolate lands in its control bit
    a_iso_latch: assert property (capture |=> ctrl[`PSL_CTRL_ISO] == $past(p_iso)) // R6
        else $error("isolate not latched");

    // Speed lands in its control bit
    a_speed_ctrl: assert property (capture |=> ctrl[`PSL_CTRL_SPD] == $past(p_spd)) // R9
        else $error("speed bit not loaded");

    // Duplex and autoneg land in their control bits
    a_dup_aneg: assert property (capture |=> // R12 R14
        ctrl[`PSL_CTRL_DUP] == $past(p_dup) && ctrl[`PSL_CTRL_ANEG] == $past(p_aneg))
        else $error("duplex or autoneg bit not loaded");

    // Abilities follow speed and duplex, the lowest ability set at every capture
    a_adv_load: assert property (capture |=> // R10 R13
        adv[8:5] == {$past(p_spd & p_dup), $past(p_spd), $past(p_dup), 1'b1})
        else $error("advertisement not loaded");

    // Images change only by capture or by a register write
    a_images_kept: assert property (!capture && !(wr_fire && (sel_ctrl || sel_adv)) |=> // R2
        $stable(ctrl) && $stable(adv))
        else $error("image changed without capture or write");

    // ====================================================
    // Checks on status flags and the bus answer

    // Far-end fault is disabled for fiber with a low speed strap
    a_far_fault: assert property (capture |=> far_fault_disable == $past(p_fiber & ~p_spd)) // R11
        else $error("far-end fault disable wrong");

    // The fault flag holds between captures
    a_fault_kept: assert property (!capture |=> $stable(far_fault_disable)) // R11
        else $error("far-end fault flag changed outside capture");

    // Power-down follows its pin one edge late, both ways
    a_power_down: assert property (!power_down_n [*2] |-> power_down) // R15
        else $error("power-down not entered");
    a_power_up: assert property (power_down_n [*2] |-> !power_down) // R15
        else $error("power-down not left");

    // Exactly one wait state on every request
    a_bus_answer: assert property (req && avs_waitrequest |=> !avs_waitrequest)
        else $error("bus answer late");

    // Unmapped reads return zero
    a_unmapped_read: assert property (avs_read && avs_waitrequest && !sel_ctrl && !sel_adv
        && !sel_stat |=> avs_readdata == 32'h0000_0000)
        else $error("unmapped read not zero");

    // Main scenarios
    c_release: cover property (in_hold ##1 drive_en ##1 &strap_pin_oe);
    c_rehold: cover property (drive_en ##1 in_hold);
    c_ctrl_write: cover property (wr_fire && sel_ctrl);
    c_fiber_noff: cover property (capture && p_fiber && !p_spd);
    c_power_down: cover property (!power_down_n ##1 power_down);

endmodule : psl_top

// ---- hw/psl_placeholder_unused.sv ----
// Intentionally empty compilation unit kept out of the design.

// ---- verif/psl_board.sv ----
// Board model: strap resistors, chip reset source and the shared pin wires.
// Assumes the bench clocks it with core_clk and raises rst_req to ask for a reset.
`timescale 1ns/10ps
`include "psl_cfg.svh"

module psl_board #(
    parameter int HOLD_CYC = `PSL_RST_MIN_CYC
) (
    // Clock and reset request
    input wire logic core_clk,
    input wire logic rst_req,
    // Strap resistor levels
    input wire logic [`PSL_STRAP_W-1:0] resistor,
    // Device pin drive
    input wire logic [`PSL_STRAP_W-1:0] strap_pin_out,
    input wire logic [`PSL_STRAP_W-1:0] strap_pin_oe,
    // Reset pin and pin levels
    output logic chip_rst_n,
    output logic [`PSL_STRAP_W-1:0] strap_pin_in
);
    int cnt = 0;

    initial chip_rst_n = 1'b0;

    // ====================
    // Reset source: low for the whole hold once requested
    always @(posedge core_clk) begin
        if (rst_req) begin
            cnt <= HOLD_CYC;
            chip_rst_n <= 1'b0;
        end else if (cnt > 1) begin
            cnt <= cnt - 1;
        end else begin
            chip_rst_n <= 1'b1;
        end
    end

    // Wire level: device drive wins, otherwise the resistor level
    assign strap_pin_in = (strap_pin_oe & strap_pin_out) | (~strap_pin_oe & resistor);
endmodule : psl_board

// ---- verif/phy_strap_latch_tb.sv ----
// Self-checking bench of the strap latch: strap patterns, bus reads, power-down.
// Assumes psl_board stands for the board and the bus answers with waitrequest.
`timescale 1ns/10ps
`include "psl_cfg.svh"
`define CHK(nm, ex, gt) begin checks_done++; if ((gt) !== (ex)) begin err_count++; \
    $display("Error %s expected %0h seen %0h", nm, ex, gt); end end

module phy_strap_latch_tb;
    // ====================
    // Clock, reset and pins
    logic core_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic rst_req = 1'b1;
    logic power_down_n = 1'b1;
    logic chip_rst_n;
    logic [12:0] resistor = `PSL_STRAP_DEF;
    logic [12:0] strap_pin_in, strap_pin_out, strap_pin_oe;
    logic [12:0] pin_func_out = 13'h0f0f;
    logic [3:0] avs_address = 4'h0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [3:0] avs_byteenable = 4'hf;
    logic [31:0] avs_writedata = 32'h0000_0000;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic [4:0] mgmt_station_addr;
    logic coding_loopback, rmii_mode, reduced_btb_mode, fiber_mode;
    logic far_fault_disable, power_down, config_done;
    int err_count = 0;
    int checks_done = 0;
    logic [12:0] pats [5] = '{`PSL_STRAP_DEF, 13'h0000, 13'h1fff, 13'h1555, 13'h0aaa};
    logic [31:0] rd;

    // Clock of 100 ns
    always #50 core_clk = ~core_clk;

    psl_top dut (.core_clk(core_clk), .sys_rst(sys_rst), .chip_rst_n(chip_rst_n),
        .power_down_n(power_down_n), .strap_pin_in(strap_pin_in),
        .strap_pin_out(strap_pin_out), .strap_pin_oe(strap_pin_oe),
        .pin_func_out(pin_func_out), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_byteenable(avs_byteenable), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .mgmt_station_addr(mgmt_station_addr), .coding_loopback(coding_loopback),
        .rmii_mode(rmii_mode), .reduced_btb_mode(reduced_btb_mode), .fiber_mode(fiber_mode),
        .far_fault_disable(far_fault_disable), .power_down(power_down),
        .config_done(config_done));

    psl_board board (.core_clk(core_clk), .rst_req(rst_req), .resistor(resistor),
        .strap_pin_out(strap_pin_out), .strap_pin_oe(strap_pin_oe),
        .chip_rst_n(chip_rst_n), .strap_pin_in(strap_pin_in));

    // ====================
    // Bus access: hold the request until waitrequest is seen low
    task automatic bus_op(input logic wr, input logic [3:0] a, input logic [31:0] wd);
        @(posedge core_clk);
        avs_address <= a;
        avs_writedata <= wd;
        avs_read <= ~wr;
        avs_write <= wr;
        do begin
            @(posedge core_clk);
        end while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask : bus_op

    // Status image expected after a capture of p
    function automatic logic [31:0] exp_stat(input logic [12:0] p, input logic pd);
        return {16'h0000, 1'b1, pd, p[12] & ~p[9], p};
    endfunction : exp_stat

    // Compare every captured output with what the pattern asks for
    task automatic check_cfg(input logic [12:0] p);
        logic [12:0] q;
        q = pin_func_out;
        q[9] = ~p[9];
        q[10] = ~p[10];
        `CHK("addr", p[4:0], mgmt_station_addr)
        `CHK("loopback", p[5], coding_loopback)
        `CHK("rmii", p[7], rmii_mode)
        `CHK("btb", p[8], reduced_btb_mode)
        `CHK("fiber", p[12], fiber_mode)
        `CHK("farfault", p[12] & ~p[9], far_fault_disable)
        `CHK("oe", 13'h1fff, strap_pin_oe)
        `CHK("pins", q, strap_pin_out)
        bus_op(1'b0, `PSL_OFS_CTRL, 32'h0);
        `CHK("ctrl", {18'h0, p[9], p[11], 1'b0, p[6], 1'b0, p[10], 8'h00}, rd)
        bus_op(1'b0, `PSL_OFS_ADV, 32'h0);
        `CHK("adv", {23'h0, p[9] & p[10], p[9], p[10], 1'b1, 5'h01}, rd)
        bus_op(1'b0, `PSL_OFS_STAT, 32'h0);
        `CHK("stat", exp_stat(p, 1'b0), rd)
    endtask : check_cfg

    // Chip reset with wrong straps first, right ones before release
    task automatic chip_reset(input logic [12:0] p);
        @(posedge core_clk);
        resistor <= ~p;
        rst_req <= 1'b1;
        @(posedge core_clk);
        rst_req <= 1'b0;
        repeat (100) @(posedge core_clk);
        `CHK("oe held", 13'h0000, strap_pin_oe)
        `CHK("done held", 1'b0, config_done)
        resistor <= p;
        while (config_done !== 1'b1) begin
            @(posedge core_clk);
        end
        @(posedge core_clk);
        resistor <= ~p;
        @(posedge core_clk);
        check_cfg(p);
    endtask : chip_reset

    // ====================
    // Verdict and end of run
    task automatic wrap_up();
        if (err_count == 0 && checks_done > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : wrap_up

    // Main sequence
    initial begin
        repeat (20) @(posedge core_clk);
        sys_rst <= 1'b0;
        rst_req <= 1'b0;
        foreach (pats[i]) begin
            chip_reset(pats[i]);
        end
        bus_op(1'b1, `PSL_OFS_STAT, 32'h0000_0000);
        bus_op(1'b0, `PSL_OFS_STAT, 32'h0);
        `CHK("stat kept", exp_stat(pats[4], 1'b0), rd)
        bus_op(1'b0, 4'hc, 32'h0);
        `CHK("unmapped", 32'h0000_0000, rd)
        // Software writes: masked control bits, lane enables, read-only selector
        bus_op(1'b1, `PSL_OFS_CTRL, 32'hffff_ffff);
        bus_op(1'b0, `PSL_OFS_CTRL, 32'h0);
        `CHK("ctrl wr", {16'h0000, `PSL_CTRL_WMASK}, rd)
        `CHK("dup pin wr", 1'b0, strap_pin_out[`PSL_IDX_DUP])
        avs_byteenable <= 4'h1;
        bus_op(1'b1, `PSL_OFS_CTRL, 32'h0);
        avs_byteenable <= 4'hf;
        bus_op(1'b0, `PSL_OFS_CTRL, 32'h0);
        `CHK("ctrl lane", {16'h0000, `PSL_CTRL_WMASK}, rd)
        bus_op(1'b1, `PSL_OFS_ADV, 32'h0);
        bus_op(1'b0, `PSL_OFS_ADV, 32'h0);
        `CHK("adv wr", {27'h0, `PSL_ADV_SEL}, rd)
        @(posedge core_clk);
        power_down_n <= 1'b0;
        repeat (3) @(posedge core_clk);
        `CHK("pwrdn", 1'b1, power_down)
        bus_op(1'b0, `PSL_OFS_STAT, 32'h0);
        `CHK("stat pd", exp_stat(pats[4], 1'b1), rd)
        power_down_n <= 1'b1;
        repeat (3) @(posedge core_clk);
        `CHK("pwrup", 1'b0, power_down)
        wrap_up();
    end

    // Watchdog against a hang
    initial begin
        repeat (20000) @(posedge core_clk);
        err_count++;
        wrap_up();
    end
endmodule : phy_strap_latch_tb
